// ---- hw/scss_consts.svh ----
`ifndef SCSS_CONSTS_SVH
`define SCSS_CONSTS_SVH
// ------------------------------------------------
// Register byte offsets
// ------------------------------------------------
`define SCSS_ADDR_CLOCK_SELECT_REG 8'h00
`define SCSS_ADDR_INTCTL 8'h04
`define SCSS_ADDR_EXTCTL 8'h08
// ------------------------------------------------
// Field positions
// ------------------------------------------------
`define SCSS_SEL_BIT 0
`define SCSS_INT_EN_BIT 7
`define SCSS_INT_RDY_BIT 6
`define SCSS_XVALID_BIT 7
`define SCSS_XMODE_LSB 4
// ------------------------------------------------
// Reset values, timing counts and response codes
// ------------------------------------------------
`define SCSS_CLOCK_SELECT_REG_RST 8'h00
`define SCSS_INTCTL_RST 8'hC0
`define SCSS_EXTCTL_RST 8'h00
`define SCSS_IRDY_EDGES 4
`define SCSS_XTAL_SETTLE_EDGES 1024
`define SCSS_RESP_OKAY 2'h0
`define SCSS_RESP_SLVERR 2'h2
`endif

// ---- hw/scss_pkg.sv ----
package scss_pkg;
  // ------------------------------------------------
  // External oscillator modes
  // ------------------------------------------------
  typedef enum logic [2:0] {
    SCSS_XM_OFF = 3'b000,
    SCSS_XM_CMOS = 3'b010,
    SCSS_XM_RC = 3'b100,
    SCSS_XM_CAP = 3'b101,
    SCSS_XM_XTAL = 3'b110,
    SCSS_XM_CERAMIC = 3'b111
  } scss_xmode_t;
  // ------------------------------------------------
  // Clock multiplexer states
  // ------------------------------------------------
  typedef enum logic [1:0] {
    SCSS_MUX_INT = 2'b00,
    SCSS_MUX_EXT = 2'b01
  } scss_mux_t;
  // Software-written control bits
  typedef struct packed {
    logic sel;
    logic int_en;
    logic [1:0] int_div;
    logic [2:0] ext_mode;
    logic [2:0] ext_freq;
  } scss_ctrl_t;
endpackage

// ---- hw/scss_top.sv ----
`timescale 1ns/1ps
`include "scss_consts.svh"
// Overview of operation
// - The system clock moves to the internal source when the select bit is 0 and that source is ready, and to the external source when it is 1 and settled.
// - The external clock stays available to peripherals whichever source drives the system clock.
// - Sources may be switched while running; the select bit takes any value, but the mux moves only to an enabled and settled source.
// - One write to the internal control register sets both the enable and the divider; selection is done in the clock select register.
// - Hardware raises the crystal valid flag once the external source has settled.
// - The external circuit supports crystal, ceramic, capacitor, RC and CMOS clock modes.
// - RC and capacitor modes are treated as needing no settling time.
// - After reset the internal source drives the system clock.
// - The internal path divides by 1, 2, 4 or 8 according to the two-bit divider field.
module scss_top
  import scss_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int SETTLE_EDGES = `SCSS_XTAL_SETTLE_EDGES,
  parameter int IRDY_EDGES = `SCSS_IRDY_EDGES
)(
  input wire logic mclk, // 20 MHz system clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic int_osc_in, // Internal oscillator raw output
  input wire logic osc_pin_in, // External oscillator pin level
  output logic osc_pin_out, // Crystal drive pin
  output logic sysclk_out, // Selected system clock
  output logic ext_clk_out, // External clock for peripherals
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  output logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp // Read response
);
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  // Tap of the internal divider for a given field value
  function automatic logic div_tap(input logic [1:0] sel, input logic lvl,
                                   input logic [2:0] cnt);
    case (sel)
      2'b11: div_tap = lvl;
      2'b10: div_tap = cnt[0];
      2'b01: div_tap = cnt[1];
      default: div_tap = cnt[2];
    endcase
  endfunction
  // Address decode shared by both paths
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == ADDR_W'(`SCSS_ADDR_CLOCK_SELECT_REG)) || (a == ADDR_W'(`SCSS_ADDR_INTCTL))
             || (a == ADDR_W'(`SCSS_ADDR_EXTCTL));
  endfunction
  // ------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------
  logic [1:0] int_sync_reg, ext_sync_reg;
  logic int_prev_reg, ext_prev_reg;
  logic int_lvl, ext_lvl, int_rise, ext_rise;
  // Two stages; only the second stage feeds any logic
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      {int_sync_reg, ext_sync_reg, int_prev_reg, ext_prev_reg} <= 6'h00;
    end
    else
    begin
      int_sync_reg <= {int_sync_reg[0], int_osc_in};
      ext_sync_reg <= {ext_sync_reg[0], osc_pin_in};
      {int_prev_reg, ext_prev_reg} <= {int_sync_reg[1], ext_sync_reg[1]};
    end
  end
  assign int_lvl = int_sync_reg[1];
  assign ext_lvl = ext_sync_reg[1];
  assign int_rise = int_lvl & ~int_prev_reg;
  assign ext_rise = ext_lvl & ~ext_prev_reg;

  // ------------------------------------------------
  // Register bus
  // ------------------------------------------------
  scss_ctrl_t ctrl_reg, ctrl_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [7:0] w_byte_reg, w_byte_next;
  logic w_lane_reg, w_lane_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic int_rdy_reg, xvalid_reg;
  logic [7:0] rd_byte;
  logic do_write;
  // Accepts address and data in either order; one write and one read at a time
  always_comb
  begin
    ctrl_next = ctrl_reg;
    {aw_have_next, aw_addr_next} = {aw_have_reg, aw_addr_reg};
    {w_have_next, w_byte_next, w_lane_next} = {w_have_reg, w_byte_reg, w_lane_reg};
    {bvalid_next, bresp_next} = {bvalid_reg, bresp_reg};
    {rvalid_next, rresp_next, rdata_next} = {rvalid_reg, rresp_reg, rdata_reg};
    rd_byte = 8'h00;
    if (s_axi_awvalid && awready_reg)
    begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg)
    begin
      w_have_next = 1'b1;
      w_byte_next = s_axi_wdata[7:0];
      w_lane_next = s_axi_wstrb[0];
    end
    do_write = aw_have_reg && w_have_reg && !bvalid_reg;
    if (do_write)
    begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = is_mapped(aw_addr_reg) ? `SCSS_RESP_OKAY : `SCSS_RESP_SLVERR;
      if (w_lane_reg)
      begin
        case (aw_addr_reg)
          ADDR_W'(`SCSS_ADDR_CLOCK_SELECT_REG): ctrl_next.sel = w_byte_reg[`SCSS_SEL_BIT];
          // Enable and divider land together; the mux follows once ready
          ADDR_W'(`SCSS_ADDR_INTCTL):
          begin
            ctrl_next.int_en = w_byte_reg[`SCSS_INT_EN_BIT];
            ctrl_next.int_div = w_byte_reg[1:0];
          end
          ADDR_W'(`SCSS_ADDR_EXTCTL):
          begin
            ctrl_next.ext_mode = w_byte_reg[`SCSS_XMODE_LSB+:3];
            ctrl_next.ext_freq = w_byte_reg[2:0];
          end
          default: ctrl_next = ctrl_reg;
        endcase
      end
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    if (s_axi_arvalid && arready_reg)
    begin
      case (s_axi_araddr)
        ADDR_W'(`SCSS_ADDR_CLOCK_SELECT_REG): rd_byte = {7'h00, ctrl_reg.sel};
        ADDR_W'(`SCSS_ADDR_INTCTL): rd_byte = {ctrl_reg.int_en, int_rdy_reg, 4'h0,
                                               ctrl_reg.int_div};
        ADDR_W'(`SCSS_ADDR_EXTCTL): rd_byte = {xvalid_reg, ctrl_reg.ext_mode, 1'b0,
                                               ctrl_reg.ext_freq};
        default: rd_byte = 8'h00;
      endcase
      rvalid_next = 1'b1;
      rdata_next = {24'h000000, rd_byte};
      rresp_next = is_mapped(s_axi_araddr) ? `SCSS_RESP_OKAY : `SCSS_RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
    // Ready drops while a beat is held, which throttles the master
    awready_next = !aw_have_next;
    wready_next = !w_have_next;
    arready_next = !rvalid_next;
  end
  // Bus registers
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ctrl_reg <= {1'b0, 1'b1, 2'h0, 3'h0, 3'h0};
      {aw_have_reg, w_have_reg, w_lane_reg, bvalid_reg, rvalid_reg} <= 5'h00;
      {awready_reg, wready_reg, arready_reg} <= 3'h0;
      {aw_addr_reg, w_byte_reg} <= '0;
      {bresp_reg, rresp_reg, rdata_reg} <= 36'h000000000;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      {aw_have_reg, w_have_reg, w_lane_reg} <= {aw_have_next, w_have_next, w_lane_next};
      {bvalid_reg, rvalid_reg} <= {bvalid_next, rvalid_next};
      {awready_reg, wready_reg, arready_reg} <= {awready_next, wready_next, arready_next};
      {aw_addr_reg, w_byte_reg} <= {aw_addr_next, w_byte_next};
      {bresp_reg, rresp_reg, rdata_reg} <= {bresp_next, rresp_next, rdata_next};
    end
  end
  // ------------------------------------------------
  // Oscillator readiness and internal divider
  // ------------------------------------------------
  logic [15:0] xcnt_reg, xcnt_next;
  logic [3:0] icnt_reg, icnt_next;
  logic [2:0] div_reg, div_next;
  logic int_rdy_next, xvalid_next, ext_on, ext_slow;
  assign ext_on = (ctrl_reg.ext_mode != SCSS_XM_OFF);
  assign ext_slow = (ctrl_reg.ext_mode == SCSS_XM_XTAL) || (ctrl_reg.ext_mode == SCSS_XM_CERAMIC);
  // Resonators count edges to settle; RC, cap and CMOS are usable at once
  always_comb
  begin
    xcnt_next = xcnt_reg;
    xvalid_next = xvalid_reg;
    icnt_next = icnt_reg;
    int_rdy_next = int_rdy_reg;
    div_next = div_reg;
    if (!ext_on)
    begin
      xcnt_next = 16'h0000;
      xvalid_next = 1'b0;
    end
    else if (!ext_slow)
      xvalid_next = 1'b1;
    else if (ext_rise && !xvalid_reg)
    begin
      xcnt_next = xcnt_reg + 16'h0001;
      if (32'(xcnt_reg) + 32'd1 >= SETTLE_EDGES)
        xvalid_next = 1'b1;
    end
    if (!ctrl_reg.int_en)
    begin
      icnt_next = 4'h0;
      int_rdy_next = 1'b0;
    end
    else if (int_rise && !int_rdy_reg)
    begin
      icnt_next = icnt_reg + 4'h1;
      if (32'(icnt_reg) + 32'd1 >= IRDY_EDGES)
        int_rdy_next = 1'b1;
    end
    if (int_rise && ctrl_reg.int_en)
      div_next = div_reg + 3'h1;
  end
  // Readiness registers; internal starts ready, as after reset it runs
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      {xcnt_reg, icnt_reg, div_reg, xvalid_reg} <= '0;
      int_rdy_reg <= 1'b1;
    end
    else
    begin
      {xcnt_reg, icnt_reg, div_reg} <= {xcnt_next, icnt_next, div_next};
      {xvalid_reg, int_rdy_reg} <= {xvalid_next, int_rdy_next};
    end
  end
  // ------------------------------------------------
  // Glitch-free source multiplexer
  // ------------------------------------------------
  scss_mux_t mux_reg, mux_next;
  logic sys_reg, sys_next, xclk_reg, xclk_next, drv_reg, drv_next;
  logic int_src, ext_src;
  assign int_src = ctrl_reg.int_en & div_tap(ctrl_reg.int_div, int_lvl, div_reg);
  assign ext_src = ext_on & ext_lvl;
  // Hand over only while output and target are both low, so no pulse is cut
  always_comb
  begin
    mux_next = mux_reg;
    case (mux_reg)
      SCSS_MUX_INT:
        if (ctrl_reg.sel && xvalid_reg && !sys_reg && !ext_src)
          mux_next = SCSS_MUX_EXT;
      SCSS_MUX_EXT:
        if (!ctrl_reg.sel && int_rdy_reg && !sys_reg && !int_src)
          mux_next = SCSS_MUX_INT;
      default: mux_next = SCSS_MUX_INT;
    endcase
    sys_next = (mux_reg == SCSS_MUX_EXT) ? ext_src : int_src;
    if (mux_next != mux_reg)
      sys_next = 1'b0;
    xclk_next = ext_src;
    drv_next = ext_slow & ~ext_lvl; // Inverting amplifier drive
  end
  // Mux registers; reset always lands on the internal source
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      mux_reg <= SCSS_MUX_INT;
      {sys_reg, xclk_reg, drv_reg} <= 3'h0;
    end
    else
    begin
      mux_reg <= mux_next;
      {sys_reg, xclk_reg, drv_reg} <= {sys_next, xclk_next, drv_next};
    end
  end
  // Outputs, all straight from flops
  assign sysclk_out = sys_reg;
  assign ext_clk_out = xclk_reg;
  assign osc_pin_out = drv_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_reset_internal: assert property ($past(!resetn) |-> mux_reg == SCSS_MUX_INT)
    else $error("source not internal after reset");
  a_ext_needs_sel: assert property ($rose(mux_reg == SCSS_MUX_EXT)
    |-> $past(ctrl_reg.sel))
    else $error("external taken without select");
  a_int_follow: assert property ((mux_reg == SCSS_MUX_INT) ##1 (mux_reg == SCSS_MUX_INT)
    |-> sys_reg == $past(int_src))
    else $error("system clock not following internal path");
  a_switch_low: assert property ((mux_reg != $past(mux_reg))
    |-> !sys_reg && !$past(sys_reg))
    else $error("source changed while clock high");
  a_ext_settled: assert property ($rose(mux_reg == SCSS_MUX_EXT) |-> $past(xvalid_reg))
    else $error("external selected before settled");
  a_fast_valid: assert property ((ext_on && !ext_slow) |-> ##1 xvalid_reg)
    else $error("RC or cap mode not valid at once");
  a_valid_drop: assert property (!ext_on |=> !xvalid_reg)
    else $error("valid flag held with source off");
  a_periph_clk: assert property (ext_on ##1 ext_on |-> xclk_reg == $past(ext_lvl))
    else $error("peripheral clock lost");
  a_div_two: assert property ((ctrl_reg.int_div == 2'b10) && int_rise && ctrl_reg.int_en
    |=> div_reg[0] != $past(div_reg[0]))
    else $error("divide by two tap not toggling");
  c_to_ext: cover property ($rose(mux_reg == SCSS_MUX_EXT));
  c_to_int: cover property ($fell(mux_reg == SCSS_MUX_EXT));
  c_xtal_settle: cover property (ext_slow ##1 $rose(xvalid_reg));
  c_unmapped: cover property (bvalid_reg && bresp_reg == `SCSS_RESP_SLVERR);
endmodule

// ---- verif/test_system_clock_source_select.sv ----
`timescale 1ns/1ps
`include "scss_consts.svh"
module test_system_clock_source_select;
  import scss_pkg::*;
  logic mclk, resetn, int_osc_in, osc_pin_in, osc_pin_out, sysclk_out, ext_clk_out;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [3:0] ic, ec;
  int bad_count, checks_done, hi_run, min_hi;
  bit watch_hi;
  scss_top #(.ADDR_W(8), .SETTLE_EDGES(8), .IRDY_EDGES(4)) dut (.mclk(mclk), .resetn(resetn),
    .int_osc_in(int_osc_in), .osc_pin_in(osc_pin_in), .osc_pin_out(osc_pin_out),
    .sysclk_out(sysclk_out), .ext_clk_out(ext_clk_out), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  // ------------------------------------------------
  // Clock, oscillators and glitch monitor
  // ------------------------------------------------
  initial
  begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  // Internal source period 10 mclk, external 14; both kept far below mclk
  // Runt watch opens only for source switching; divider changes may cut a phase
  always @(posedge mclk)
  begin
    ic <= (ic == 4) ? 4'h0 : ic + 4'h1;
    ec <= (ec == 6) ? 4'h0 : ec + 4'h1;
    if (ic == 4) int_osc_in <= ~int_osc_in;
    if (ec == 6) osc_pin_in <= ~osc_pin_in;
    if (resetn && sysclk_out === 1'b1) hi_run <= hi_run + 1;
    else
    begin
      if (watch_hi && hi_run > 0 && hi_run < min_hi) min_hi <= hi_run;
      hi_run <= 0;
    end
  end
  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge mclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    // Address and data may be taken on different edges
    while (!(ad && wd))
    begin
      @(posedge mclk);
      if (!ad && awready) begin ad = 1; awvalid <= 1'b0; end
      if (!wd && wready) begin wd = 1; wvalid <= 1'b0; end
    end
    while (bvalid !== 1'b1) @(posedge mclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge mclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk(r, `SCSS_RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d, e);
    chk(r, `SCSS_RESP_OKAY);
  endtask
  function automatic logic pick(input int w);
    return (w == 0) ? sysclk_out : (w == 1) ? ext_clk_out : osc_pin_out;
  endfunction
  // Cycles between two rising edges of the chosen output, bounded
  task automatic per(input int w, input int exp);
    int n, k;
    for (k = 0; k < 4; k++)
    begin
      if (k == 2) n = 0;
      while (pick(w) !== k[0] && n < 3000) begin @(posedge mclk); n++; end
    end
    chk(n, exp);
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_reset();
    int i;
    rd(`SCSS_ADDR_CLOCK_SELECT_REG, 32'h0000_0000);
    rd(`SCSS_ADDR_INTCTL, 32'h0000_00C0);
    rd(`SCSS_ADDR_EXTCTL, 32'h0000_0000);
    per(0, 80);
    for (i = 0; i < 30; i++) begin @(posedge mclk); chk(ext_clk_out, 1'b0); end
  endtask
  // Selecting an external source that is off must not move the clock
  task automatic t_refuse();
    wr(`SCSS_ADDR_CLOCK_SELECT_REG, 32'h0000_0001);
    rd(`SCSS_ADDR_CLOCK_SELECT_REG, 32'h0000_0001);
    per(0, 80);
    wr(`SCSS_ADDR_CLOCK_SELECT_REG, 32'h0000_0000);
  endtask
  task automatic t_div();
    int c;
    for (c = 0; c < 4; c++)
    begin
      wr(`SCSS_ADDR_INTCTL, 32'h80 | c);
      rd(`SCSS_ADDR_INTCTL, 32'hC0 | c);
      per(0, 10 << (3 - c));
    end
  endtask
  task automatic t_modes();
    scss_xmode_t m[3] = '{SCSS_XM_CMOS, SCSS_XM_RC, SCSS_XM_CAP};
    int i;
    for (i = 0; i < 3; i++)
    begin
      wr(`SCSS_ADDR_EXTCTL, 32'({m[i], 4'h2}));
      rd(`SCSS_ADDR_EXTCTL, 32'({1'b1, m[i], 4'h2}));
      per(1, 14);
      chk(osc_pin_out, 1'b0);
    end
  endtask
  // Resonator modes need settling pin edges; a crystal is left 1 ms before its flag is read
  task automatic t_xtal();
    scss_xmode_t m[2] = '{SCSS_XM_CERAMIC, SCSS_XM_XTAL};
    int i;
    for (i = 0; i < 2; i++)
    begin
      wr(`SCSS_ADDR_EXTCTL, 32'h0);
      wr(`SCSS_ADDR_EXTCTL, 32'({m[i], 4'h5}));
      if (m[i] == SCSS_XM_XTAL)
        repeat (20000) @(posedge mclk);
      else
        rd(`SCSS_ADDR_EXTCTL, 32'({1'b0, m[i], 4'h5}));
      repeat (200) @(posedge mclk);
      rd(`SCSS_ADDR_EXTCTL, 32'({1'b1, m[i], 4'h5}));
      per(2, 14);
    end
  endtask
  task automatic t_switch();
    watch_hi = 1'b1;
    wr(`SCSS_ADDR_CLOCK_SELECT_REG, 32'h1);
    repeat (50) @(posedge mclk);
    per(0, 14);
    wr(`SCSS_ADDR_INTCTL, 32'h0);
    rd(`SCSS_ADDR_INTCTL, 32'h0);
    per(0, 14);
    wr(`SCSS_ADDR_INTCTL, 32'h83);
    wr(`SCSS_ADDR_CLOCK_SELECT_REG, 32'h0);
    repeat (100) @(posedge mclk);
    rd(`SCSS_ADDR_INTCTL, 32'hC3);
    per(0, 10);
  endtask
  task automatic t_unmap();
    logic [31:0] d;
    logic [1:0] r;
    axw(8'h0C, 32'hFF, r);
    chk(r, `SCSS_RESP_SLVERR);
    axr(8'h0C, d, r);
    chk(d, 32'h0);
    chk(r, `SCSS_RESP_SLVERR);
  endtask
  // ------------------------------------------------
  // Run control
  // ------------------------------------------------
  task automatic summarize();
    $display("bad_count=%0d checks_done=%0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #3_000_000;
    bad_count++;
    summarize();
  end
  initial
  begin
    resetn = 0; int_osc_in = 0; osc_pin_in = 0; ic = 0; ec = 0;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
    bad_count = 0; checks_done = 0; hi_run = 0; min_hi = 1000;
    watch_hi = 1'b0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_refuse();
    t_div();
    t_modes();
    t_xtal();
    t_switch();
    t_unmap();
    chk(min_hi >= 4, 1'b1);
    summarize();
  end
endmodule
